// ---- inc/lash_map.vh ----
// opcode patterns, field positions, register offsets and reset values for the shift and mask unit
`ifndef LASH_MAP_VH
`define LASH_MAP_VH
// opcode upper-bit patterns
`define LASH_OP_MEMAND_HI     8'h18
`define LASH_OP_BYTEAND_HI    7'b1001_000
`define LASH_OP_ASRI_HI       11'b1111_1111_101
`define LASH_OP_ASRT_HI       15'b1111_1111_0110_010
`define LASH_OP_ASR64I_HI     12'h568
`define LASH_OP_ASR64T        16'h562C
`define LASH_OP_ALIGN         16'h761B
`define LASH_OP_RPT_HI        8'hF6
// field positions
`define LASH_HALF_BIT         8
`define LASH_HALF_BIT_ASRT    0
`define LASH_HALF_BIT_ASRI    4
// register offsets (word index on the plain port)
`define LASH_REG_ACC          4'h0
`define LASH_REG_PROD         4'h1
`define LASH_REG_MCAND        4'h2
`define LASH_REG_SP           4'h3
`define LASH_REG_FLAGS        4'h4
`define LASH_REG_REPEAT_COUNTER         4'h5
`define LASH_REG_INSTR        4'h6
`define LASH_REG_IMM          4'h7
`define LASH_REG_MEMDATA      4'h8
`define LASH_REG_CTRL         4'h9
// flag bit positions in the flags register
`define LASH_FLG_N            0
`define LASH_FLG_Z            1
`define LASH_FLG_C            2
`define LASH_FLG_SPA          3
// control bits
`define LASH_CTRL_GO          0
`define LASH_CTRL_ALIGN_DONE  1
// reset values
`define LASH_RST_WORD32       32'h0000_0000
`define LASH_RST_WORD16       16'h0000
`define LASH_RST_SP           16'h0400
`define LASH_RST_FLAGS        4'h0
`endif

// ---- verilog/lash_shifter.v ----
// arithmetic right shifter for 16-bit and 64-bit operands with carry out
`timescale 1ns/1ps
module lash_shifter (
  input  wire [63:0] wide_in,
  input  wire [15:0] half_in,
  input  wire [5:0]  amount,
  input  wire        wide_sel,
  output reg  [63:0] wide_out,
  output reg  [15:0] half_out,
  output reg         carry_out
);
  reg [128:0] wide_ext;
  reg [32:0]  half_ext;
  always @* begin
    // sign copies above, a guard bit below catches the last bit shifted out
    wide_ext = {{64{wide_in[63]}}, wide_in, 1'b0} >> amount;
    // five count bits: an immediate shift reaches sixteen
    half_ext = {{16{half_in[15]}}, half_in, 1'b0} >> amount[4:0];
    wide_out = wide_ext[64:1];
    half_out = half_ext[16:1];
    if (amount == 6'd0) begin
      carry_out = 1'b0;
    end else if (wide_sel) begin
      carry_out = wide_ext[0];
    end else begin
      carry_out = half_ext[0];
    end
  end
endmodule // lash_shifter

// ---- verilog/lash_unit.v ----
// execution slice for masking, stack alignment and arithmetic right shifts
`timescale 1ns/1ps
`include "lash_map.vh"
module lash_unit (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output reg         mem_wr,
  output reg  [15:0] mem_wdata,
  output reg         busy
);
  localparam ST_IDLE = 3'b001;
  localparam ST_DEC2 = 3'b010;
  localparam ST_EXEC = 3'b100;

  reg [2:0]  state_q;
  reg [31:0] acc_q;
  reg [31:0] prod_q;
  reg [31:0] mcand_q;
  reg [15:0] sp_q;
  reg        n_q;
  reg        z_q;
  reg        c_q;
  reg        spa_q;
  reg [15:0] repeat_counter_q;
  reg [15:0] instr_q;
  reg [15:0] imm_q;
  reg [15:0] memdata_q;
  reg        rpt_pend_q;
  reg        align_done_q;

  wire [15:0] shift_count_half = mcand_q[31:16];

  // pick_half picks the half from the select bit
  function [15:0] pick_half;
    input [31:0] acc;
    input        upper;
    begin
      pick_half = upper ? acc[31:16] : acc[15:0];
    end
  endfunction

  // decoded instruction class
  wire dec_memand  = (instr_q[15:8] == `LASH_OP_MEMAND_HI);
  wire dec_byteand = (instr_q[15:9] == `LASH_OP_BYTEAND_HI);
  wire dec_asri    = (instr_q[15:5] == `LASH_OP_ASRI_HI);
  wire dec_asrt    = (instr_q[15:1] == `LASH_OP_ASRT_HI);
  wire dec_asr64i  = (instr_q[15:4] == `LASH_OP_ASR64I_HI);
  wire dec_asr64t  = (instr_q == `LASH_OP_ASR64T);
  wire dec_align   = (instr_q == `LASH_OP_ALIGN);
  wire dec_rpt     = (instr_q[15:8] == `LASH_OP_RPT_HI);
  wire dec_wide    = dec_asr64i | dec_asr64t;

  wire half_upper  = dec_asrt ? instr_q[`LASH_HALF_BIT_ASRT] :
                     dec_asri ? instr_q[`LASH_HALF_BIT_ASRI] : instr_q[`LASH_HALF_BIT];

  reg [5:0] shamt;
  always @* begin
    if (dec_asri || dec_asr64i) begin
      shamt = {2'b00, instr_q[3:0]} + 6'd1;
    end else if (dec_asrt) begin
      shamt = {2'b00, shift_count_half[3:0]};
    end else if (dec_asr64t) begin
      shamt = shift_count_half[5:0];
    end else begin
      shamt = 6'd0;
    end
  end

  wire [63:0] sh_wide;
  wire [15:0] sh_half;
  wire        sh_carry;

  lash_shifter u_shifter (
    .wide_in   ({acc_q, prod_q}),
    .half_in   (pick_half(acc_q, half_upper)),
    .amount    (shamt),
    .wide_sel  (dec_wide),
    .wide_out  (sh_wide),
    .half_out  (sh_half),
    .carry_out (sh_carry)
  );

  wire [15:0] memand_res  = memdata_q & imm_q;
  wire [15:0] byteand_res = pick_half(acc_q, half_upper) & {8'h00, instr_q[7:0]};

  wire go_wr = reg_wr && (reg_addr == `LASH_REG_CTRL) && reg_wdata[`LASH_CTRL_GO];

  always @(posedge clk) begin
    if (sys_rst) begin
      state_q      <= ST_IDLE;
      acc_q        <= `LASH_RST_WORD32;
      prod_q       <= `LASH_RST_WORD32;
      mcand_q      <= `LASH_RST_WORD32;
      sp_q         <= `LASH_RST_SP;
      n_q          <= 1'b0;
      z_q          <= 1'b0;
      c_q          <= 1'b0;
      spa_q        <= 1'b0;
      repeat_counter_q       <= `LASH_RST_WORD16;
      instr_q      <= `LASH_RST_WORD16;
      imm_q        <= `LASH_RST_WORD16;
      memdata_q    <= `LASH_RST_WORD16;
      rpt_pend_q   <= 1'b0;
      align_done_q <= 1'b0;
      mem_wr       <= 1'b0;
      mem_wdata    <= `LASH_RST_WORD16;
    end else begin
      mem_wr <= 1'b0;
      if (reg_wr && state_q == ST_IDLE) begin
        case (reg_addr)
          `LASH_REG_ACC:     acc_q     <= reg_wdata;
          `LASH_REG_PROD:    prod_q    <= reg_wdata;
          `LASH_REG_MCAND:   mcand_q   <= reg_wdata;
          `LASH_REG_SP:      sp_q      <= reg_wdata[15:0];
          `LASH_REG_FLAGS: begin
            n_q   <= reg_wdata[`LASH_FLG_N];
            z_q   <= reg_wdata[`LASH_FLG_Z];
            c_q   <= reg_wdata[`LASH_FLG_C];
            spa_q <= reg_wdata[`LASH_FLG_SPA];
          end
          `LASH_REG_REPEAT_COUNTER:    repeat_counter_q    <= reg_wdata[15:0];
          `LASH_REG_INSTR:   instr_q   <= reg_wdata[15:0];
          `LASH_REG_IMM:     imm_q     <= reg_wdata[15:0];
          `LASH_REG_MEMDATA: memdata_q <= reg_wdata[15:0];
          default: ;
        endcase
      end
      case (state_q)
        ST_IDLE: begin
          if (go_wr) begin
            align_done_q <= 1'b0;
            state_q      <= ST_DEC2;
          end
        end
        ST_DEC2: begin
          // flag settles in second decode stage
          if (dec_align) begin
            spa_q <= sp_q[0];
            align_done_q <= 1'b1;
          end
          state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          // a repeat prefix arms the counter; any other op here runs once
          if (dec_rpt) begin
            repeat_counter_q     <= {8'h00, instr_q[7:0]};
            rpt_pend_q <= 1'b1;
          end else begin
            if (rpt_pend_q) begin
              repeat_counter_q <= `LASH_RST_WORD16;
            end
            rpt_pend_q <= 1'b0;
          end
          if (dec_memand) begin
            mem_wr    <= 1'b1;
            mem_wdata <= memand_res;
            memdata_q <= memand_res;
            n_q <= memand_res[15];
            z_q <= (memand_res == 16'h0000);
          end else if (dec_byteand) begin
            if (half_upper) acc_q[31:16] <= byteand_res;
            else acc_q[15:0] <= byteand_res;
            n_q <= byteand_res[15];
            z_q <= (byteand_res == 16'h0000);
          end else if (dec_align) begin
            if (sp_q[0]) sp_q <= sp_q + 16'h0001;
          end else if (dec_asri || dec_asrt) begin
            if (half_upper) acc_q[31:16] <= sh_half;
            else acc_q[15:0] <= sh_half;
            // carry is last bit out, or clear on zero count
            c_q <= sh_carry;
            n_q <= sh_half[15];
            z_q <= (sh_half == 16'h0000);
          end else if (dec_wide) begin
            acc_q  <= sh_wide[63:32];
            prod_q <= sh_wide[31:0];
            // carry from shifter, zero count clears
            c_q <= sh_carry;
            n_q <= sh_wide[63];
            z_q <= (sh_wide == 64'h0000_0000_0000_0000);
          end
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always @* begin
    busy = (state_q != ST_IDLE);
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= `LASH_RST_WORD32;
    end else if (reg_rd) begin
      case (reg_addr)
        `LASH_REG_ACC:     reg_rdata <= acc_q;
        `LASH_REG_PROD:    reg_rdata <= prod_q;
        `LASH_REG_MCAND:   reg_rdata <= mcand_q;
        `LASH_REG_SP:      reg_rdata <= {16'h0000, sp_q};
        `LASH_REG_FLAGS:   reg_rdata <= {28'h000_0000, spa_q, c_q, z_q, n_q};
        `LASH_REG_REPEAT_COUNTER:    reg_rdata <= {16'h0000, repeat_counter_q};
        `LASH_REG_INSTR:   reg_rdata <= {16'h0000, instr_q};
        `LASH_REG_IMM:     reg_rdata <= {16'h0000, imm_q};
        `LASH_REG_MEMDATA: reg_rdata <= {16'h0000, memdata_q};
        `LASH_REG_CTRL:    reg_rdata <= {30'h0000_0000, align_done_q, busy};
        default:           reg_rdata <= `LASH_RST_WORD32;
      endcase
    end else begin
      reg_rdata <= `LASH_RST_WORD32;
    end
  end
endmodule // lash_unit

// ---- verif/lash_unit_asserts.sv ----
// port checker for the shift and mask unit
`timescale 1ns/1ps
`include "lash_map.vh"
module lash_unit_asserts (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        mem_wr,
  input wire logic [15:0] mem_wdata,
  input wire logic        busy
);
  logic [15:0] imm_q;
  logic [15:0] md_q;
  wire         go = reg_wr && reg_addr == `LASH_REG_CTRL && reg_wdata[0];
  // operands as last written while idle, to predict the write-back
  always @(posedge clk) begin
    if (reg_wr && !busy && reg_addr == `LASH_REG_IMM) imm_q <= reg_wdata[15:0];
    if (reg_wr && !busy && reg_addr == `LASH_REG_MEMDATA) md_q <= reg_wdata[15:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_MASK_RESULT: assert property (mem_wr |-> mem_wdata == (imm_q & md_q))
    else $error("masked word written back is wrong");
  AST_MASK_ONCE: assert property (mem_wr |=> !mem_wr)
    else $error("write-back lasted more than one cycle");
  AST_MASK_AFTER_EXEC: assert property (mem_wr |-> $past(busy) && $past(busy, 2))
    else $error("write-back outside its execution slot");
  AST_WB_HOLD: assert property (!mem_wr |-> $stable(mem_wdata))
    else $error("write-back word moved without a write");
  AST_GO_DEC2: assert property (go && !busy |=> busy)
    else $error("start not followed by second decode stage");
  AST_BUSY_SPAN: assert property ($rose(busy) |-> busy [*2] ##1 !busy)
    else $error("execution did not take exactly two cycles");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(go))
    else $error("execution began without a start");
  AST_READ_WINDOW: assert property (reg_rdata != 32'h0000_0000 |-> $past(reg_rd))
    else $error("read data outside its slot");
endmodule // lash_unit_asserts
bind lash_unit lash_unit_asserts lash_unit_asserts_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_wr(mem_wr),
  .mem_wdata(mem_wdata), .busy(busy));

// ---- verif/testbench.sv ----
// self-checking bench for the shift and mask unit
`timescale 1ns/1ps
`include "lash_map.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire  [31:0] reg_rdata;
  wire         mem_wr;
  wire  [15:0] mem_wdata;
  wire         busy;
  int          n_errors = 0;
  int          total_checks = 0;
  logic [31:0] acc, prod, mc;
  logic [15:0] sp, md, imm, hf, ins;
  logic [63:0] w;
  logic        n, z, c, stack_aligned_flag, h;
  logic [3:0]  s;
  int          op, cnt;
  lash_unit lash_unit_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .busy(busy));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  // results are readable two edges after the start is taken; the task waits three
  task automatic run(input logic [15:0] i, input logic [15:0] m);
    wr(`LASH_REG_INSTR, {16'h0000, i});
    wr(`LASH_REG_IMM, {16'h0000, m});
    wr(`LASH_REG_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk);
  endtask
  task automatic results;
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #500_000;
    n_errors++;
    results;
  end
  initial begin
    void'($urandom(32'h8e30));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    {stack_aligned_flag, c, z, n} = 4'h0;
    // every index, unmapped ones included
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], (a == 3) ? 32'h0000_0400 : 32'h0000_0000);
    end
    for (int i = 0; i < 84; i++) begin
      op = i % 7;
      {acc, prod, mc} = {$urandom, $urandom, $urandom};
      {sp, md, imm, s, h} = {$urandom, $urandom};
      if (i % 3 == 0) mc[21:16] = 6'h00;
      if (i % 2 == 1) s = 4'hf;
      if (i % 5 == 0) {acc, prod, md} = 80'h0;
      wr(`LASH_REG_ACC, acc);
      wr(`LASH_REG_PROD, prod);
      wr(`LASH_REG_MCAND, mc);
      wr(`LASH_REG_SP, {16'h0000, sp});
      wr(`LASH_REG_MEMDATA, {16'h0000, md});
      if (i % 4 == 1) begin
        run({`LASH_OP_RPT_HI, imm[7:0]}, 16'h0000);
        rd(`LASH_REG_REPEAT_COUNTER, {24'h00_0000, imm[7:0]});
      end
      case (op)
        0: ins = {`LASH_OP_MEMAND_HI, imm[15:8]};
        1: ins = {`LASH_OP_BYTEAND_HI, h, imm[7:0]};
        2: ins = {`LASH_OP_ASRI_HI, h, s};
        3: ins = {`LASH_OP_ASRT_HI, h};
        4: ins = {`LASH_OP_ASR64I_HI, s};
        5: ins = `LASH_OP_ASR64T;
        default: ins = `LASH_OP_ALIGN;
      endcase
      cnt = (op == 3) ? mc[19:16] : (op == 5) ? mc[21:16] : s + 1;
      hf = h ? acc[31:16] : acc[15:0];
      w = {acc, prod};
      if (op == 0) begin
        md = md & imm;
        {n, z} = {md[15], md == 16'h0000};
      end else if (op == 6) begin
        stack_aligned_flag = sp[0];
        sp = sp + {15'h0000, sp[0]};
      end else if (op >= 4) begin
        c = (cnt == 0) ? 1'b0 : w[cnt - 1];
        w = $signed(w) >>> cnt;
        {acc, prod} = w;
        {n, z} = {w[63], w == 64'h0};
      end else begin
        if (op == 1) hf = hf & {8'h00, imm[7:0]};
        else c = (cnt == 0) ? 1'b0 : hf[cnt - 1];
        if (op != 1) hf = $signed(hf) >>> cnt;
        {n, z} = {hf[15], hf == 16'h0000};
        if (h) acc[31:16] = hf;
        else acc[15:0] = hf;
      end
      run(ins, imm);
      rd(`LASH_REG_ACC, acc);
      rd(`LASH_REG_PROD, prod);
      rd(`LASH_REG_SP, {16'h0000, sp});
      rd(`LASH_REG_FLAGS, {28'h000_0000, stack_aligned_flag, c, z, n});
      rd(`LASH_REG_MEMDATA, {16'h0000, md});
      rd(`LASH_REG_REPEAT_COUNTER, 32'h0000_0000);
    end
    results;
  end
endmodule // testbench
